// File: ehfp_programmer.sv
// Notes on behaviour
// - Program strobe fall starts timed operations internally.
// - Reads follow command and address, not strobe.
// - Select block 0 steers later commands there.
// - Block 1 covers only addresses below 2000H.
// - Block 1 selected at entry, after chip erase.
// - Erase leaves bytes FFH; program needs erased.
// - Chip erase clears all, ignores lock, clears bits.
// - Block erase selected block, refused when locked.
// - Sector erase 128-byte sector, refused when locked.
// - Byte program suppressed when any lock set.
// - Byte verify returns code byte unless locked.
// - Security bit commands set; chip erase clears.
// - Config bit command sets; chip erase clears.
// - Host mode runs oscillator, holds CPU reset.
// - Ready/busy low during operation, high after.
// - Busy verify polls inverted bit 3 (zero during erases), rest zero.
// - Status reads at 60H and 61H.
// - Status reads do not arm the device.
// - Erase times 150, 100, 30 ms maximum.
// - Bit program 80 us, block select 500 ns.
// - Byte program 50 us; host erases first.
// - Four-bit command decode with high-address qualifiers.
// - Commands accepted only 1 ms after arming.
// - Non Read-ID commands before arming are ignored.
// - Commands are strobe-low pulses; others undefined.
`timescale 1ns/1ps
`include "ehfp_map.svh"

module ehfp_programmer
	import ehfp_pkg::*;
#(
	parameter int CE_CYCLES = `EHFP_CE_CYC,
	parameter int BE_CYCLES = `EHFP_BE_CYC,
	parameter int SE_CYCLES = `EHFP_SE_CYC,
	parameter int ARM_CYCLES = `EHFP_ARM_CYC,
	parameter logic [7:0] MFR_ID = 8'h5C, // Arbitrary value.
	parameter logic [7:0] DEV_ID = 8'h3A // Arbitrary value.
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Host pins (asynchronous).
	input wire logic reset_pin,
	input wire logic host_mode_strobe_n,
	input wire logic prog_strobe_n,
	input wire logic external_access_n,
	input wire logic [3:0] cmd_pins,
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] addr_lo,
	// Data port, two-way.
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	// Ready/busy pin.
	output logic ready_busy,
	// Chip-level control.
	input wire logic clock_double_status,
	output logic osc_enable,
	output logic cpu_hold_reset,
	// Flash array.
	output ehfp_op_t flash_op,
	output logic flash_op_active,
	output logic [16:0] flash_addr,
	output logic [7:0] flash_wdata,
	output logic [16:0] flash_rd_addr,
	input wire logic [7:0] flash_rd_data
);

	localparam int PIN_W = 32;

	logic [PIN_W-1:0] pins_clean;
	logic rst_pin_f;
	logic hms_n_f;
	logic prog_n_f;
	logic ext_acc_n_f;
	logic [3:0] cmd_f;
	logic [7:0] ah_f;
	logic [7:0] al_f;
	logic [7:0] din_f;
	logic hms_n_q;
	logic prog_n_q;
	logic hm_enter;
	logic hm_stay;
	logic prog_fall;
	logic accept;
	logic locked;
	logic is_status_addr;
	logic is_read_id;
	ehfp_state_t state;
	ehfp_op_t next_op;
	logic [`EHFP_TIMER_W-1:0] timer;
	logic [`EHFP_TIMER_W-1:0] next_dur;
	logic block1_sel;
	logic sec_one;
	logic sec_two;
	logic sec_three;
	logic cfg_bit;
	logic [7:0] last_data;
	logic last_was_erase;
	logic [15:0] addr16;

	// Maps a host address to {block, address} under the current block selection.
	function automatic logic [16:0] map_addr(input logic sel1, input logic [15:0] a);
		logic blk;
		blk = sel1 && (a < `EHFP_BLOCK1_LIMIT);
		return {blk, a};
	endfunction

	// All host pins pass the three-stage filter before any logic looks at them; clock_double_status is read unfiltered.
	ehfp_pin_sync #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin_raw({reset_pin, host_mode_strobe_n, prog_strobe_n, external_access_n,
			cmd_pins, addr_hi, addr_lo, data_in}),
		.pin_clean(pins_clean)
	);

	assign {rst_pin_f, hms_n_f, prog_n_f, ext_acc_n_f, cmd_f, ah_f, al_f, din_f} = pins_clean;
	assign addr16 = {ah_f, al_f};

	// Edge history of the two strobes. It resets to the filter's reset level, so
	// no false fall is seen while the filtered pins climb to their idle level.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hms_n_q <= 1'b0;
			prog_n_q <= 1'b0;
		end else begin
			hms_n_q <= hms_n_f;
			prog_n_q <= prog_n_f;
		end
	end

	assign hm_enter = rst_pin_f && hms_n_q && !hms_n_f;
	assign hm_stay = rst_pin_f && !hms_n_f;
	assign prog_fall = prog_n_q && !prog_n_f;
	assign locked = sec_one || sec_two || sec_three;
	assign is_status_addr = (ah_f == 8'h00) && ((al_f == `EHFP_ADDR_SEC_CFG_STATUS) ||
		(al_f == `EHFP_ADDR_CLK_MODE_STATUS));
	assign is_read_id = (cmd_f == `EHFP_CMD_READ_ID) && !is_status_addr;
	// Commands start only when armed, idle and external access is high.
	assign accept = (state == HM_READY) && prog_fall && ext_acc_n_f;

	// Command decode into an operation and its duration.
	always_comb begin
		next_op = OP_NONE;
		next_dur = `EHFP_TIMER_W'(1);
		unique case (cmd_f)
			`EHFP_CMD_CHIP_ERASE: begin
				next_op = OP_CHIP_ERASE;
				next_dur = `EHFP_TIMER_W'(CE_CYCLES);
			end
			`EHFP_CMD_BLOCK_ERASE: begin
				next_op = locked ? OP_NONE : OP_BLOCK_ERASE;
				next_dur = `EHFP_TIMER_W'(BE_CYCLES);
			end
			`EHFP_CMD_SECTOR_ERASE: begin
				next_op = locked ? OP_NONE : OP_SECTOR_ERASE;
				next_dur = `EHFP_TIMER_W'(SE_CYCLES);
			end
			`EHFP_CMD_BYTE_PROGRAM: begin
				next_op = locked ? OP_NONE : OP_BYTE_PROGRAM;
				next_dur = `EHFP_TIMER_W'(`EHFP_PB_CYC);
			end
			`EHFP_CMD_SELECT: begin
				if (ah_f == `EHFP_AH_SELECT_BLOCK0 || ah_f == `EHFP_AH_SELECT_BLOCK1) begin
					next_op = OP_SELECT_BLOCK;
					next_dur = `EHFP_TIMER_W'(`EHFP_PSB_CYC);
				end else if (ah_f == `EHFP_AH_PROG_CONFIG) begin
					next_op = OP_PROG_BIT;
					next_dur = `EHFP_TIMER_W'(`EHFP_PS_CYC);
				end
			end
			`EHFP_CMD_PROG_SEC_ONE, `EHFP_CMD_PROG_SEC_TWO, `EHFP_CMD_PROG_SEC_THREE: begin
				next_op = OP_PROG_BIT;
				next_dur = `EHFP_TIMER_W'(`EHFP_PS_CYC);
			end
			default: begin
				next_op = OP_NONE;
			end
		endcase
	end

	// Sequencer: entry, arming delay, and timed operations. Leaving host mode
	// aborts whatever is running, since the oscillator stops with it.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= HM_OFF;
			timer <= '0;
			flash_op <= OP_NONE;
			flash_op_active <= 1'b0;
		end else if (state != HM_OFF && !hm_stay) begin
			state <= HM_OFF;
			timer <= '0;
			flash_op <= OP_NONE;
			flash_op_active <= 1'b0;
		end else begin
			unique case (state)
				HM_OFF: begin
					if (hm_enter) begin
						state <= HM_UNARMED;
					end
				end
				HM_UNARMED: begin
					if (is_read_id) begin
						state <= HM_ARMING;
						timer <= `EHFP_TIMER_W'(ARM_CYCLES);
					end
				end
				HM_ARMING: begin
					if (timer <= `EHFP_TIMER_W'(1)) begin
						state <= HM_READY;
						timer <= '0;
					end else begin
						timer <= timer - `EHFP_TIMER_W'(1);
					end
				end
				HM_READY: begin
					if (accept && next_op != OP_NONE) begin
						state <= HM_BUSY;
						timer <= next_dur;
						flash_op <= next_op;
						flash_op_active <= 1'b1;
					end
				end
				HM_BUSY: begin
					if (timer <= `EHFP_TIMER_W'(1)) begin
						state <= HM_READY;
						timer <= '0;
						flash_op <= OP_NONE;
						flash_op_active <= 1'b0;
					end else begin
						timer <= timer - `EHFP_TIMER_W'(1);
					end
				end
			endcase
		end
	end

	// Array address and data for the operation being started. Sector erase
	// hands over the sector base; the array itself writes erased bytes as FFH.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flash_addr <= '0;
			flash_wdata <= `EHFP_RST_BYTE;
		end else if (state == HM_READY && accept && next_op != OP_NONE) begin
			unique case (next_op)
				OP_SECTOR_ERASE: flash_addr <= map_addr(block1_sel,
					addr16 & `EHFP_SECTOR_MASK);
				OP_BLOCK_ERASE: flash_addr <= {block1_sel, 16'h0000};
				default: flash_addr <= map_addr(block1_sel, addr16);
			endcase
			flash_wdata <= (next_op == OP_BYTE_PROGRAM) ? din_f : `EHFP_ERASED_BYTE;
		end
	end

	// Block selection: block 1 on entry and after chip erase, else as commanded.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			block1_sel <= `EHFP_RST_BLOCK1_SEL;
		end else if (hm_enter) begin
			block1_sel <= 1'b1;
		end else if (state == HM_BUSY && flash_op == OP_CHIP_ERASE && timer <= `EHFP_TIMER_W'(1)
				&& hm_stay) begin
			block1_sel <= 1'b1;
		end else if (state == HM_READY && accept && next_op == OP_SELECT_BLOCK) begin
			block1_sel <= (ah_f == `EHFP_AH_SELECT_BLOCK1);
		end
	end

	// Security and configuration bits: set by their commands, cleared only when
	// a chip erase completes.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sec_one <= 1'b0;
			sec_two <= 1'b0;
			sec_three <= 1'b0;
			cfg_bit <= 1'b0;
		end else if (state == HM_BUSY && flash_op == OP_CHIP_ERASE && timer <= `EHFP_TIMER_W'(1)
				&& hm_stay) begin
			sec_one <= 1'b0;
			sec_two <= 1'b0;
			sec_three <= 1'b0;
			cfg_bit <= 1'b0;
		end else if (state == HM_READY && accept && next_op == OP_PROG_BIT) begin
			if (cmd_f == `EHFP_CMD_PROG_SEC_ONE) sec_one <= 1'b1;
			if (cmd_f == `EHFP_CMD_PROG_SEC_TWO) sec_two <= 1'b1;
			if (cmd_f == `EHFP_CMD_PROG_SEC_THREE) sec_three <= 1'b1;
			if (cmd_f == `EHFP_CMD_SELECT) cfg_bit <= 1'b1;
		end
	end

	// Last byte loaded, kept for polling while busy.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_data <= `EHFP_RST_BYTE;
			last_was_erase <= 1'b0;
		end else if (state == HM_READY && accept && next_op != OP_NONE) begin
			last_data <= din_f;
			last_was_erase <= (next_op == OP_CHIP_ERASE || next_op == OP_BLOCK_ERASE ||
				next_op == OP_SECTOR_ERASE);
		end
	end

	// Read path: re-evaluated every cycle from command and address alone, so it
	// never waits for the program strobe. Output lags the pins by the filter delay.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flash_rd_addr <= '0;
			data_out <= `EHFP_RST_BYTE;
			data_oe_n <= 1'b1;
		end else begin
			flash_rd_addr <= map_addr(block1_sel, addr16);
			data_out <= `EHFP_RST_BYTE;
			data_oe_n <= 1'b1;
			if (state != HM_OFF && cmd_f == `EHFP_CMD_READ_ID) begin
				data_oe_n <= 1'b0;
				if (ah_f == 8'h00) begin
					unique case (al_f)
						`EHFP_ADDR_MFR_ID: data_out <= MFR_ID;
						`EHFP_ADDR_DEV_ID: data_out <= DEV_ID;
						`EHFP_ADDR_SEC_CFG_STATUS: begin
							data_out[`EHFP_SEC_STAT_CFG_BIT] <= cfg_bit;
							data_out[`EHFP_SEC_STAT_ONE_BIT] <= sec_one;
							data_out[`EHFP_SEC_STAT_TWO_BIT] <= sec_two;
							data_out[`EHFP_SEC_STAT_THREE_BIT] <= sec_three;
						end
						`EHFP_ADDR_CLK_MODE_STATUS: begin
							data_out[`EHFP_CLK_STAT_DOUBLE_BIT] <= clock_double_status;
						end
						default: data_out <= `EHFP_RST_BYTE;
					endcase
				end
			end else if ((state == HM_READY || state == HM_BUSY) &&
					cmd_f == `EHFP_CMD_BYTE_VERIFY) begin
				data_oe_n <= 1'b0;
				if (locked) begin
					data_out <= `EHFP_RST_BYTE;
				end else if (state == HM_BUSY) begin
					data_out[`EHFP_POLL_BIT] <= !last_was_erase &&
						!last_data[`EHFP_POLL_BIT];
				end else begin
					data_out <= flash_rd_data;
				end
			end
		end
	end

	// Pins toward the host and the chip.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ready_busy <= 1'b1;
			osc_enable <= 1'b0;
			cpu_hold_reset <= 1'b0;
		end else begin
			ready_busy <= !(state == HM_BUSY && hm_stay);
			osc_enable <= (state != HM_OFF) ? hm_stay : hm_enter;
			cpu_hold_reset <= (state != HM_OFF) ? hm_stay : hm_enter;
		end
	end

endmodule // ehfp_programmer

// File: ehfp_map.svh
`ifndef EHFP_MAP_SVH
`define EHFP_MAP_SVH

// Clock rate used to turn times into cycle counts.
`define EHFP_CLK_KHZ 50000

// Command codes on {cmd_hi[1:0], cmd_lo[1:0]}.
`define EHFP_CMD_READ_ID 4'h0
`define EHFP_CMD_CHIP_ERASE 4'h1
`define EHFP_CMD_BLOCK_ERASE 4'hD
`define EHFP_CMD_SECTOR_ERASE 4'hB
`define EHFP_CMD_BYTE_PROGRAM 4'hE
`define EHFP_CMD_BYTE_VERIFY 4'hC
`define EHFP_CMD_SELECT 4'h9
`define EHFP_CMD_PROG_SEC_ONE 4'hF
`define EHFP_CMD_PROG_SEC_TWO 4'h3
`define EHFP_CMD_PROG_SEC_THREE 4'h5

// High address values that qualify the select command.
`define EHFP_AH_SELECT_BLOCK0 8'h55
`define EHFP_AH_SELECT_BLOCK1 8'hA5
`define EHFP_AH_PROG_CONFIG 8'h5A

// Read-type addresses (low byte, high byte zero).
`define EHFP_ADDR_MFR_ID 8'h30
`define EHFP_ADDR_DEV_ID 8'h31
`define EHFP_ADDR_SEC_CFG_STATUS 8'h60
`define EHFP_ADDR_CLK_MODE_STATUS 8'h61

// Status field positions.
`define EHFP_SEC_STAT_CFG_BIT 3
`define EHFP_SEC_STAT_ONE_BIT 2
`define EHFP_SEC_STAT_TWO_BIT 1
`define EHFP_SEC_STAT_THREE_BIT 0
`define EHFP_CLK_STAT_DOUBLE_BIT 1
`define EHFP_POLL_BIT 3

// Address layout.
`define EHFP_BLOCK1_LIMIT 16'h2000
`define EHFP_SECTOR_MASK 16'hFF80
`define EHFP_ERASED_BYTE 8'hFF

// Reset values.
`define EHFP_RST_BLOCK1_SEL 1'b1
`define EHFP_RST_BYTE 8'h00

// Times as printed, in their own units.
`define EHFP_T_CE_MS 150
`define EHFP_T_BE_MS 100
`define EHFP_T_SE_MS 30
`define EHFP_T_PB_US 50
`define EHFP_T_PS_US 80
`define EHFP_T_PSB_NS 500
`define EHFP_T_ARM_MS 1

// Cycle counts (shorter times round down; none below one cycle).
`define EHFP_CE_CYC (`EHFP_T_CE_MS * `EHFP_CLK_KHZ)
`define EHFP_BE_CYC (`EHFP_T_BE_MS * `EHFP_CLK_KHZ)
`define EHFP_SE_CYC (`EHFP_T_SE_MS * `EHFP_CLK_KHZ)
`define EHFP_ARM_CYC (`EHFP_T_ARM_MS * `EHFP_CLK_KHZ)
`define EHFP_PB_CYC ((`EHFP_T_PB_US * `EHFP_CLK_KHZ) / 1000)
`define EHFP_PS_CYC ((`EHFP_T_PS_US * `EHFP_CLK_KHZ) / 1000)
`define EHFP_PSB_CYC ((`EHFP_T_PSB_NS * `EHFP_CLK_KHZ) / 1000000)

`define EHFP_TIMER_W 23

`endif

// File: ehfp_pkg.sv
package ehfp_pkg;

	// Host-mode sequencer states.
	typedef enum logic [2:0] {
		HM_OFF,
		HM_UNARMED,
		HM_ARMING,
		HM_READY,
		HM_BUSY
	} ehfp_state_t;

	// Operation handed to the flash array.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_CHIP_ERASE,
		OP_BLOCK_ERASE,
		OP_SECTOR_ERASE,
		OP_BYTE_PROGRAM,
		OP_SELECT_BLOCK,
		OP_PROG_BIT
	} ehfp_op_t;

endpackage

// File: ehfp_pin_sync.sv
`timescale 1ns/1ps

module ehfp_pin_sync #(
	parameter int WIDTH = 32
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Raw pins and filtered levels.
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_clean
);

	genvar i;

	// Three stages per bit; a change is accepted only when stages two and three agree,
	// so a one-cycle glitch at the second stage never reaches the sequencer.
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					pin_clean[i] <= 1'b0;
				end else begin
					s1 <= pin_raw[i];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						pin_clean[i] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule // ehfp_pin_sync

// File: ehfp_flash_model.sv
`timescale 1ns/1ps

module ehfp_flash_model
	import ehfp_pkg::*;
(
	// Clock.
	input wire logic clk_sys,
	// Array requests from the sequencer.
	input wire ehfp_op_t flash_op,
	input wire logic flash_op_active,
	input wire logic [16:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	// Read side.
	input wire logic [16:0] flash_rd_addr,
	output logic [7:0] flash_rd_data
);
	logic [7:0] mem [0:131071];
	logic was_active = 1'b0;

	// The array starts erased so programs need no prior erase here.
	initial begin
		for (int i = 0; i < 131072; i++) begin
			mem[i] = 8'hFF;
		end
	end

	// Reads are combinational, as the sequencer expects.
	assign flash_rd_data = mem[flash_rd_addr];

	// Applying an operation at its start is enough for later reads.
	always @(posedge clk_sys) begin
		was_active <= flash_op_active;
		if (flash_op_active && !was_active) begin
			for (int i = 0; i < 131072; i++) begin
				if (flash_op == OP_CHIP_ERASE) begin
					mem[i] = 8'hFF;
				end
				if (flash_op == OP_BLOCK_ERASE && i[16] == flash_addr[16]) begin
					mem[i] = 8'hFF;
				end
				if (flash_op == OP_SECTOR_ERASE && i[16:7] == flash_addr[16:7]) begin
					mem[i] = 8'hFF;
				end
			end
			if (flash_op == OP_BYTE_PROGRAM) begin
				mem[flash_addr] = flash_wdata;
			end
		end
	end
endmodule // ehfp_flash_model

// File: ehfp_chk.sv
`timescale 1ns/1ps

module ehfp_chk
	import ehfp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Watched pins.
	input wire logic prog_strobe_n,
	input wire logic ready_busy,
	input wire logic osc_enable,
	input wire logic cpu_hold_reset,
	// Array controls.
	input wire ehfp_op_t flash_op,
	input wire logic flash_op_active,
	input wire logic [16:0] flash_addr,
	input wire logic [7:0] flash_wdata
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	logic strobe_q;
	logic [3:0] since_fall;
	logic [12:0] run_len;

	// Cycles since a strobe fall; it saturates so an old fall never looks recent.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strobe_q <= 1'b1;
			since_fall <= 4'hF;
		end else begin
			strobe_q <= prog_strobe_n;
			if (strobe_q && !prog_strobe_n) begin
				since_fall <= 4'h0;
			end else if (since_fall != 4'hF) begin
				since_fall <= since_fall + 4'h1;
			end
		end
	end

	// Length of the running operation.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			run_len <= 13'h0000;
		end else begin
			run_len <= flash_op_active ? run_len + 13'h0001 : 13'h0000;
		end
	end

	sequence s_idle2;
		!flash_op_active [*2];
	endsequence
	sequence s_busy2;
		!ready_busy [*2];
	endsequence

	property p_start_cause;
		$rose(flash_op_active) |-> since_fall <= 4'h8;
	endproperty
	property p_busy_shown;
		$rose(flash_op_active) |=> s_busy2;
	endproperty
	property p_idle_ready;
		s_idle2 |-> ready_busy;
	endproperty
	property p_host_pair;
		osc_enable |-> cpu_hold_reset;
	endproperty
	property p_no_op_off;
		!osc_enable && !$past(osc_enable) |-> !flash_op_active;
	endproperty
	property p_erase_ff;
		flash_op_active && flash_op inside {OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_SECTOR_ERASE}
			|-> flash_wdata == 8'hFF;
	endproperty
	property p_high_block0;
		flash_op_active && flash_op inside {OP_BYTE_PROGRAM, OP_SECTOR_ERASE}
			&& flash_addr[15:0] >= 16'h2000 |-> !flash_addr[16];
	endproperty
	property p_hold;
		flash_op_active && $past(flash_op_active) |-> $stable(flash_addr) && $stable(flash_op);
	endproperty
	property p_prog_len;
		flash_op_active && flash_op == OP_BYTE_PROGRAM |-> run_len < 13'h09C4;
	endproperty
	property p_sel_len;
		flash_op_active && flash_op == OP_SELECT_BLOCK |-> run_len < 13'h0019;
	endproperty

	a_start_cause: assert property (p_start_cause) else $error("op start without strobe");
	a_busy_shown: assert property (p_busy_shown) else $error("busy not shown");
	a_idle_ready: assert property (p_idle_ready) else $error("busy while idle");
	a_host_pair: assert property (p_host_pair) else $error("cpu not held");
	a_no_op_off: assert property (p_no_op_off) else $error("op outside host mode");
	a_erase_ff: assert property (p_erase_ff) else $error("erase value wrong");
	a_high_block0: assert property (p_high_block0) else $error("high address in block 1");
	a_hold: assert property (p_hold) else $error("op changed while running");
	a_prog_len: assert property (p_prog_len) else $error("program too long");
	a_sel_len: assert property (p_sel_len) else $error("select too long");
endmodule // ehfp_chk

// File: ehfp_programmer_bench.sv
`timescale 1ns/1ps

module ehfp_programmer_bench
	import ehfp_pkg::*;
;
	localparam int ARM = 60;
	localparam logic [7:0] MFR = 8'h5C; // Arbitrary value.

	logic clk_sys, rst_b, reset_pin, host_mode_strobe_n, prog_strobe_n, external_access_n;
	logic clock_double_status, data_oe_n, ready_busy, osc_enable, cpu_hold_reset;
	logic flash_op_active;
	logic [3:0] cmd_pins;
	logic [7:0] addr_hi, addr_lo, data_in, data_out, flash_wdata, flash_rd_data;
	logic [16:0] flash_addr, flash_rd_addr;
	ehfp_op_t flash_op;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;

	ehfp_programmer #(.CE_CYCLES(200), .BE_CYCLES(150), .SE_CYCLES(100), .ARM_CYCLES(ARM),
		.MFR_ID(MFR)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reset_pin(reset_pin),
		.host_mode_strobe_n(host_mode_strobe_n), .prog_strobe_n(prog_strobe_n),
		.external_access_n(external_access_n), .cmd_pins(cmd_pins), .addr_hi(addr_hi),
		.addr_lo(addr_lo), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.ready_busy(ready_busy), .clock_double_status(clock_double_status),
		.osc_enable(osc_enable), .cpu_hold_reset(cpu_hold_reset), .flash_op(flash_op),
		.flash_op_active(flash_op_active), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));

	ehfp_flash_model u_flash (.clk_sys(clk_sys), .flash_op(flash_op),
		.flash_op_active(flash_op_active), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// A hang is cut short well past the expected run length.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures = failures + 1;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pins change just after a rising edge; outputs are sampled at falling edges.
	task automatic put(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cmd_pins <= c;
		{addr_hi, addr_lo} <= a;
		data_in <= d;
	endtask

	// The wait covers the pin filter plus the array read.
	task automatic rd(input logic [3:0] c, input logic [15:0] a, output logic [7:0] v);
		put(c, a, 8'h00);
		cyc(12);
		@(negedge clk_sys);
		v = data_out;
		chk({7'h00, data_oe_n}, 8'h00);
	endtask

	task automatic pulse(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic busy);
		put(c, a, d);
		cyc(1);
		prog_strobe_n <= 1'b0;
		cyc(8);
		prog_strobe_n <= 1'b1;
		@(negedge clk_sys);
		chk({7'h00, ready_busy}, {7'h00, !busy});
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (ready_busy !== 1'b1 && n < 5000) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h00, ready_busy}, 8'h01);
	endtask

	task automatic op(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic busy);
		pulse(c, a, d, busy);
		wait_ready();
	endtask

	task automatic t_enter;
		logic [7:0] v;
		@(posedge clk_sys);
		reset_pin <= 1'b1;
		cyc(8);
		host_mode_strobe_n <= 1'b0;
		external_access_n <= 1'b1;
		cyc(8);
		@(negedge clk_sys);
		chk({6'h00, osc_enable, cpu_hold_reset}, 8'h03);
		op(4'hE, 16'h2100, 8'h5A, 1'b0);
		rd(4'h0, 16'h0060, v);
		chk(v, 8'h00);
		cyc(ARM + 10);
		op(4'hE, 16'h2100, 8'h5A, 1'b0);
		rd(4'h0, 16'h0030, v);
		chk(v, MFR);
		cyc(ARM + 10);
		$display("test enter done");
	endtask

	task automatic t_prog;
		logic [7:0] v;
		op(4'hE, 16'h2100, 8'hA5, 1'b1);
		rd(4'hC, 16'h2100, v);
		chk(v, 8'hA5);
		pulse(4'hE, 16'h2180, 8'h52, 1'b1);
		rd(4'hC, 16'h2180, v);
		chk(v, 8'h08);
		wait_ready();
		$display("test program done");
	endtask

	task automatic t_block;
		logic [7:0] v;
		op(4'hE, 16'h0010, 8'h11, 1'b1);
		op(4'h9, 16'h5500, 8'h00, 1'b1);
		op(4'hE, 16'h0010, 8'h22, 1'b1);
		rd(4'hC, 16'h0010, v);
		chk(v, 8'h22);
		op(4'h9, 16'hA500, 8'h00, 1'b1);
		rd(4'hC, 16'h0010, v);
		chk(v, 8'h11);
		rd(4'hC, 16'h2100, v);
		chk(v, 8'hA5);
		$display("test block done");
	endtask

	task automatic t_erase;
		logic [7:0] v;
		pulse(4'hB, 16'h0010, 8'h00, 1'b1);
		rd(4'hC, 16'h0010, v);
		chk(v, 8'h00);
		wait_ready();
		rd(4'hC, 16'h0010, v);
		chk(v, 8'hFF);
		op(4'h9, 16'h5500, 8'h00, 1'b1);
		rd(4'hC, 16'h0010, v);
		chk(v, 8'h22);
		op(4'hD, 16'h0000, 8'h00, 1'b1);
		rd(4'hC, 16'h2100, v);
		chk(v, 8'hFF);
		$display("test erase done");
	endtask

	task automatic t_lock;
		logic [7:0] v;
		op(4'hF, 16'h0000, 8'h00, 1'b1);
		rd(4'h0, 16'h0060, v);
		chk(v, 8'h04);
		op(4'h3, 16'h0000, 8'h00, 1'b1);
		op(4'h5, 16'h0000, 8'h00, 1'b1);
		op(4'h9, 16'h5A00, 8'h00, 1'b1);
		rd(4'h0, 16'h0060, v);
		chk(v, 8'h0F);
		rd(4'h0, 16'h0061, v);
		chk(v & 8'h02, 8'h02);
		@(posedge clk_sys);
		clock_double_status <= 1'b0;
		rd(4'h0, 16'h0061, v);
		chk(v & 8'h02, 8'h00);
		op(4'hE, 16'h2100, 8'h77, 1'b0);
		op(4'hB, 16'h2100, 8'h00, 1'b0);
		op(4'hD, 16'h0000, 8'h00, 1'b0);
		rd(4'hC, 16'h2100, v);
		chk(v, 8'h00);
		op(4'h1, 16'h0000, 8'h00, 1'b1);
		rd(4'h0, 16'h0060, v);
		chk(v, 8'h00);
		op(4'hE, 16'h0010, 8'h33, 1'b1);
		op(4'h9, 16'h5500, 8'h00, 1'b1);
		rd(4'hC, 16'h0010, v);
		chk(v, 8'hFF);
		@(posedge clk_sys);
		reset_pin <= 1'b0;
		cyc(10);
		@(negedge clk_sys);
		chk({5'h00, data_oe_n, osc_enable, cpu_hold_reset}, 8'h04);
		$display("test lock done");
	endtask

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		reset_pin = 1'b0;
		host_mode_strobe_n = 1'b1;
		prog_strobe_n = 1'b1;
		external_access_n = 1'b0;
		clock_double_status = 1'b1;
		cmd_pins = 4'hC;
		addr_hi = 8'h00;
		addr_lo = 8'h00;
		data_in = 8'h00;
		cyc(3);
		rst_b <= 1'b1;
		cyc(6);
		t_enter();
		t_prog();
		t_block();
		t_erase();
		t_lock();
		end_of_test();
	end
endmodule // ehfp_programmer_bench

bind ehfp_programmer ehfp_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.prog_strobe_n(prog_strobe_n), .ready_busy(ready_busy), .osc_enable(osc_enable),
	.cpu_hold_reset(cpu_hold_reset), .flash_op(flash_op), .flash_op_active(flash_op_active),
	.flash_addr(flash_addr), .flash_wdata(flash_wdata));
